//--- rtl/port_status_pkg.sv
/*
  shared constants and types for the port status and adapter power controller.
  assumes a 20 MHz pod clock and a plain one-cycle register port.
*/
package port_status_pkg;

  localparam int unsigned CLK_KHZ        = 20_000;
  localparam int unsigned BLINK_HALF_MS  = 100;
  localparam int unsigned BLINK_CYCLES_D = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned BLINK_W        = 24;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ID_W   = 4;

  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EXPECT = 4'h8;

  // control register fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_START   = 4;
  localparam int unsigned CTRL_DONE    = 5;

  // status register fields
  localparam int unsigned ST_SEL_LSB   = 0;
  localparam int unsigned ST_POWER     = 4;
  localparam int unsigned ST_FAULT     = 5;
  localparam int unsigned ST_VREF_SER  = 6;
  localparam int unsigned ST_VREF_PAR  = 7;
  localparam int unsigned ST_ID_MATCH  = 8;
  localparam int unsigned ST_ID_LSB    = 12;

  localparam logic [ID_W-1:0]   ID_NONE      = 4'h0;
  localparam logic [ID_W-1:0]   EXPECT_RESET = 4'h0;

  typedef enum logic [1:0] {
    SEL_IN_SYSTEM = 2'b00,
    SEL_PARALLEL  = 2'b01,
    SEL_ADAPTER   = 2'b10
  } port_sel_e;

  typedef enum logic [1:0] {
    LED_OFF   = 2'b00,
    LED_RED   = 2'b01,
    LED_AMBER = 2'b10,
    LED_GREEN = 2'b11
  } led_color_e;

  typedef enum logic [1:0] {
    PWR_IDLE  = 2'b00,
    PWR_ON    = 2'b01,
    PWR_FAULT = 2'b10
  } pwr_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic              overcurrent;
    logic              vref_par;
    logic              vref_ser;
    logic [ID_W-1:0]   adapter_id;
  } pod_pins_s;

  typedef struct packed {
    led_color_e        serial_led;
    led_color_e        parallel_led;
    logic              adapter_power;
    logic              adapter_active_led;
  } pod_out_s;

endpackage : port_status_pkg

//--- rtl/port_status_power_control.sv
/*
  port indicator and adapter power controller, all logic in one module.
  assumes pins arrive asynchronously and the register master follows the
  one-cycle strobe protocol with read data in the following cycle.
*/
`timescale 1ns/1ps
module port_status_power_control #(
  parameter int unsigned BLINK_CYCLES = port_status_pkg::BLINK_CYCLES_D
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire port_status_pkg::reg_req_s  req,
  output logic [port_status_pkg::DATA_W-1:0] rdata,
  input  wire port_status_pkg::pod_pins_s pins,
  output port_status_pkg::pod_out_s       pod_out
);
  import port_status_pkg::*;

  if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (64'd1 << BLINK_W)) begin : g_bad_blink
    $error("blink cycle count out of range");
  end

  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYCLES - 1);

  typedef struct packed {
    pod_pins_s         sy1;
    pod_pins_s         sy2;
    pod_pins_s         sy3;
    pod_pins_s         filt;
    port_sel_e         sel;
    logic [ID_W-1:0]   expect_id;
    pwr_state_e        pwr;
    logic [BLINK_W-1:0] blink_cnt;
    logic              blink_phase;
    logic [DATA_W-1:0] rdata;
    pod_out_s          out;
  } state_s;

  localparam state_s STATE_RESET = '{
    sy1:         '0,
    sy2:         '0,
    sy3:         '0,
    filt:        '0,
    sel:         SEL_IN_SYSTEM,
    expect_id:   EXPECT_RESET,
    pwr:         PWR_IDLE,
    blink_cnt:   '0,
    blink_phase: 1'b0,
    rdata:       '0,
    out:         '{serial_led: LED_RED, parallel_led: LED_RED,
                   adapter_power: 1'b0, adapter_active_led: 1'b0}
  };

  state_s state_reg;
  state_s state_next;

  // colour of one target port from selection and sensed reference
  function automatic led_color_e port_color(input logic selected, input logic vref);
    if (!selected) begin
      port_color = LED_RED;
    end else if (!vref) begin
      port_color = LED_AMBER;
    end else begin
      port_color = LED_GREEN;
    end
  endfunction : port_color

  // code 3 names no port, so a write carrying it leaves the selection alone
  function automatic logic sel_code_ok(input logic [1:0] code);
    sel_code_ok = (code != 2'b11);
  endfunction : sel_code_ok

  // control read gives back the selection only; start and done are pulses
  function automatic logic [DATA_W-1:0] ctrl_word(input port_sel_e sel);
    ctrl_word                    = '0;
    ctrl_word[CTRL_SEL_LSB +: 2] = sel;
  endfunction : ctrl_word

  // status word; unused bits read as zero
  function automatic logic [DATA_W-1:0] status_word(
    input port_sel_e       sel,
    input logic            power,
    input logic            fault,
    input logic            vref_ser,
    input logic            vref_par,
    input logic            match,
    input logic [ID_W-1:0] id
  );
    status_word                    = '0;
    status_word[ST_SEL_LSB +: 2]   = sel;
    status_word[ST_POWER]          = power;
    status_word[ST_FAULT]          = fault;
    status_word[ST_VREF_SER]       = vref_ser;
    status_word[ST_VREF_PAR]       = vref_par;
    status_word[ST_ID_MATCH]       = match;
    status_word[ST_ID_LSB +: ID_W] = id;
  endfunction : status_word

  // expected adapter code sits in the low bits
  function automatic logic [DATA_W-1:0] expect_word(input logic [ID_W-1:0] id);
    expect_word            = '0;
    expect_word[ID_W-1:0]  = id;
  endfunction : expect_word

  // power sequencing; a start needs the adapter port and a matching adapter
  function automatic pwr_state_e pwr_step(
    input pwr_state_e cur,
    input logic       start,
    input logic       done,
    input logic       on_adapter,
    input logic       match,
    input logic       oc
  );
    pwr_step = cur;
    unique case (cur)
      PWR_IDLE, PWR_FAULT: begin
        if (start && on_adapter && match) begin
          pwr_step = PWR_ON;
        end
      end
      PWR_ON: begin
        if (oc) begin
          // fault wins over a same-cycle done or deselect
          pwr_step = PWR_FAULT;
        end else if (done || !on_adapter || !match) begin
          pwr_step = PWR_IDLE;
        end
      end
      default: begin
        pwr_step = PWR_IDLE;
      end
    endcase
  endfunction : pwr_step

  // one tick of the blink timer as {phase, count}; it idles outside a fault
  // so every fault opens on a lit phase
  function automatic logic [BLINK_W:0] blink_step(
    input logic               in_fault,
    input logic [BLINK_W-1:0] cnt,
    input logic               phase
  );
    if (!in_fault) begin
      blink_step = '0;
    end else if (cnt == BLINK_LAST) begin
      blink_step = {!phase, {BLINK_W{1'b0}}};
    end else begin
      blink_step = {phase, BLINK_W'(cnt + 1'b1)};
    end
  endfunction : blink_step

  logic       id_match;
  logic       wr_ctrl;
  logic       start_req;
  logic       done_req;
  logic       power_on;
  led_color_e blink_color;

  always_comb begin
    state_next = state_reg;

    // a pin change counts only once the second and third stages agree
    state_next.sy1 = pins;
    state_next.sy2 = state_reg.sy1;
    state_next.sy3 = state_reg.sy2;
    if (state_reg.sy2 == state_reg.sy3) begin
      state_next.filt = state_reg.sy3;
    end

    id_match = (state_reg.filt.adapter_id != ID_NONE) &&
               (state_reg.filt.adapter_id == state_reg.expect_id);

    wr_ctrl   = req.wr && (req.addr == OFS_CTRL);
    start_req = wr_ctrl && req.wdata[CTRL_START];
    done_req  = wr_ctrl && req.wdata[CTRL_DONE];

    if (wr_ctrl && sel_code_ok(req.wdata[CTRL_SEL_LSB +: 2])) begin
      state_next.sel = port_sel_e'(req.wdata[CTRL_SEL_LSB +: 2]);
    end
    if (req.wr && req.addr == OFS_EXPECT) begin
      state_next.expect_id = req.wdata[ID_W-1:0];
    end

    state_next.pwr = pwr_step(state_reg.pwr,
                              start_req,
                              done_req,
                              state_next.sel == SEL_ADAPTER,
                              id_match,
                              state_reg.filt.overcurrent);

    {state_next.blink_phase, state_next.blink_cnt} =
      blink_step(state_reg.pwr == PWR_FAULT,
                 state_reg.blink_cnt,
                 state_reg.blink_phase);

    power_on    = (state_next.pwr == PWR_ON);
    blink_color = state_next.blink_phase ? LED_OFF : LED_RED;

    state_next.out.adapter_power      = power_on;
    state_next.out.adapter_active_led = power_on;
    if (state_next.pwr == PWR_FAULT) begin
      state_next.out.serial_led   = blink_color;
      state_next.out.parallel_led = blink_color;
    end else begin
      // adapter selection leaves both unselected, so both read red
      state_next.out.serial_led   = port_color(state_next.sel == SEL_IN_SYSTEM,
                                               state_reg.filt.vref_ser);
      state_next.out.parallel_led = port_color(state_next.sel == SEL_PARALLEL,
                                               state_reg.filt.vref_par);
    end

    // read data stands only in the cycle after the strobe
    state_next.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        OFS_CTRL: begin
          state_next.rdata = ctrl_word(state_reg.sel);
        end
        OFS_STATUS: begin
          state_next.rdata = status_word(state_reg.sel,
                                         state_reg.out.adapter_power,
                                         state_reg.pwr == PWR_FAULT,
                                         state_reg.filt.vref_ser,
                                         state_reg.filt.vref_par,
                                         id_match,
                                         state_reg.filt.adapter_id);
        end
        OFS_EXPECT: begin
          state_next.rdata = expect_word(state_reg.expect_id);
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata   = state_reg.rdata;
  assign pod_out = state_reg.out;

endmodule : port_status_power_control

//--- sim/port_status_chk.sv
/* checker for the port status and power controller.
   assumes it is bound to the controller's own ports. */
`timescale 1ns/1ps
module port_status_chk #(
  parameter int unsigned BLINK_CYCLES = 4
) (
  input wire logic                                clk,
  input wire logic                                rst_b,
  input wire port_status_pkg::reg_req_s           req,
  input wire logic [port_status_pkg::DATA_W-1:0] rdata,
  input wire port_status_pkg::pod_pins_s          pins,
  input wire port_status_pkg::pod_out_s           pod_out
);
  import port_status_pkg::*;
  logic [BLINK_W-1:0] off_cnt;
  logic               dark;
  assign dark = pod_out.serial_led == LED_OFF;
  // a new start may cut the dark half short, so only unpowered ends are judged
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) off_cnt <= '0;
    else off_cnt <= dark ? off_cnt + 1'b1 : '0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence done_wr;
    req.wr && req.addr == OFS_CTRL && req.wdata[CTRL_DONE] && !req.wdata[CTRL_START];
  endsequence
  sequence oc_held;
    pins.overcurrent && pod_out.adapter_power ##1 pins.overcurrent [*5];
  endsequence
  a_active_led: assert property (
    pod_out.adapter_active_led == pod_out.adapter_power) else $error("active led wrong");
  a_start_only: assert property (
    $rose(pod_out.adapter_power) |->
      $past(req.wr && req.addr == OFS_CTRL && req.wdata[CTRL_START]))
    else $error("power without start");
  a_done_off: assert property (done_wr |=> !pod_out.adapter_power)
    else $error("power after done");
  a_adapter_red: assert property (
    pod_out.adapter_power |-> pod_out.serial_led == LED_RED && pod_out.parallel_led == LED_RED)
    else $error("leds not red");
  a_oc_cut: assert property (oc_held |-> !pod_out.adapter_power)
    else $error("power on overcurrent");
  a_blink_both: assert property (dark |-> pod_out.parallel_led == LED_OFF)
    else $error("blink apart");
  a_dark_off: assert property (dark |-> !pod_out.adapter_power)
    else $error("dark while powered");
  a_blink_half: assert property (
    $fell(dark) && !pod_out.adapter_power && off_cnt != 0 |-> off_cnt == BLINK_W'(BLINK_CYCLES))
    else $error("blink period wrong");
endmodule : port_status_chk

bind port_status_power_control port_status_chk #(.BLINK_CYCLES(BLINK_CYCLES)) chk_i (
  .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .pins(pins), .pod_out(pod_out));

//--- sim/adapter_model.sv
/* adapter and target model driving the sense pins.
   assumes the bench picks what is fitted. */
`timescale 1ns/1ps
module adapter_model (
  input  wire logic [3:0]            id,
  input  wire logic                  oc,
  input  wire logic                  vs,
  input  wire logic                  vp,
  output port_status_pkg::pod_pins_s pins
);
  import port_status_pkg::*;
  // a shorted socket reads as steady over-current
  assign pins = '{overcurrent: oc, vref_par: vp, vref_ser: vs, adapter_id: id};
endmodule : adapter_model

//--- sim/testbench.sv
/* bench for the port status and power controller.
   assumes the adapter model drives the sense pins. */
`timescale 1ns/1ps
module testbench;
  import port_status_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  reg_req_s          req = '0;
  logic [DATA_W-1:0] rdata;
  pod_pins_s         pins;
  pod_out_s          pod_out;
  logic [3:0]        id = 4'h0;
  logic              oc = 1'b0;
  logic              vs = 1'b0;
  logic              vp = 1'b0;
  int                failures = 0;
  int                check_count = 0;
  always #25 clk = ~clk;
  port_status_power_control #(.BLINK_CYCLES(4)) DUT (.clk(clk), .rst_b(rst_b),
    .req(req), .rdata(rdata), .pins(pins), .pod_out(pod_out));
  adapter_model adapter (.id(id), .oc(oc), .vs(vs), .vp(vp), .pins(pins));
  task automatic stop_test;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
  endtask : bus
  task automatic leds(input led_color_e s, input led_color_e p, input logic pw);
    chk({26'h0, pod_out.serial_led, pod_out.parallel_led, pod_out.adapter_power,
      pod_out.adapter_active_led}, {26'h0, s, p, pw, pw});
  endtask : leds
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    step(8);
    leds(LED_AMBER, LED_RED, 1'b0);
    bus(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    vs <= 1'b1;
    id <= 4'h5;
    step(8);
    leds(LED_GREEN, LED_RED, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    leds(LED_RED, LED_AMBER, 1'b0);
    vp <= 1'b1;
    step(8);
    leds(LED_RED, LED_GREEN, 1'b0);
    bus(1'b1, OFS_EXPECT, 32'h0000_0006);
    bus(1'b1, OFS_CTRL, 32'h0000_0012);
    leds(LED_RED, LED_RED, 1'b0);
    bus(1'b1, OFS_EXPECT, 32'h0000_0005);
    bus(1'b1, OFS_CTRL, 32'h0000_0012);
    leds(LED_RED, LED_RED, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdata, 32'h0000_51D2);
    step(1);
    chk(rdata, 32'h0000_0000);
    bus(1'b0, OFS_EXPECT, 32'h0000_0000);
    chk(rdata, 32'h0000_0005);
    bus(1'b1, OFS_CTRL, 32'h0000_0022);
    leds(LED_RED, LED_RED, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h0000_0012);
    oc <= 1'b1;
    for (int i = 0; i < 12 && pod_out.serial_led !== LED_OFF; i++) step(1);
    leds(LED_OFF, LED_OFF, 1'b0);
    step(4);
    leds(LED_RED, LED_RED, 1'b0);
    oc <= 1'b0;
    step(9);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdata & 32'h0000_0030, 32'h0000_0020);
    bus(1'b1, OFS_CTRL, 32'h0000_0012);
    leds(LED_RED, LED_RED, 1'b1);
    rst_b <= 1'b0;
    step(2);
    leds(LED_RED, LED_RED, 1'b0);
    rst_b <= 1'b1;
    step(8);
    leds(LED_GREEN, LED_RED, 1'b0);
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : testbench
